// [pkg/master_regs_pkg.sv]
// constants for the master register bank
package master_regs_pkg;
  localparam int        ADDR_W = 8;
  localparam int        DATA_W = 8;
  localparam logic [7:0] OFF_RESET_ID  = 8'h00;
  localparam logic [7:0] OFF_CONFIG    = 8'h01;
  localparam logic [7:0] OFF_INT_STAT  = 8'h02;
  localparam logic [7:0] OFF_CLK_MON   = 8'h04;
  localparam logic [7:0] OFF_MCTRL     = 8'h05;
  localparam logic [7:0] OFF_SYNTH     = 8'h06;
  localparam logic [7:0] OFF_RECOV     = 8'h07;
  localparam int TEST_SEL_BIT = 7;
  // reset/identity fields
  localparam int SW_RESET_BIT = 7;
  localparam int TYPE_LSB     = 4;
  localparam int REV_LSB      = 0;
  // configuration fields
  localparam int RXINV_BIT  = 1;
  localparam int RX_AVAIL_INV_BIT = 2;
  localparam int TX_AVAIL_INV_BIT = 3;
  localparam int APRDI_BIT  = 4;
  localparam int ALRDI_BIT  = 5;
  localparam int AFEBE_BIT  = 6;
  localparam logic [7:0] CONFIG_RESET = 8'h70;
  localparam logic [7:0] CONFIG_MASK  = 8'h7E;
  // interrupt status fields
  localparam int TXLOCK_IRQ_BIT = 7;
  localparam int LCD_IRQ_BIT    = 6;
  localparam int RXLOCK_IRQ_BIT = 5;
  // master control / synth / recovery fields
  localparam int LCD_EN_BIT   = 7;
  localparam int LCD_V_BIT    = 6;
  localparam int FIXED_PTR_BIT = 5;
  localparam logic [7:0] MCTRL_RESET = 8'h20;
  localparam logic [7:0] MCTRL_MASK  = 8'hA7;
  localparam int TXLOCK_V_BIT  = 3;
  localparam int RXLOCK_V_BIT  = 3;
  localparam int RXREF_V_BIT   = 4;
  localparam int LOCK_EN_BIT   = 1;
  localparam logic [7:0] SYNTH_MASK = 8'h03;
  localparam int SYNC_STAGES = 2;
  localparam int N_CLKMON    = 4;
  localparam int N_BLOCKS    = 5;
endpackage : master_regs_pkg

// [hw/edge_sync.sv]
// two-flop synchroniser bank with rising-edge detect
`timescale 1ns/1ns
`default_nettype none
module edge_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  if (WIDTH < 1) begin : g_width_check
    $error("edge_sync: WIDTH must be at least 1");
  end

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.s2;
  assign rise_out  = st_r.s2 & ~st_r.s3;
endmodule // edge_sync
`default_nettype wire

// [hw/master_regs.sv]
// master register bank: reset, identity, configuration, status, clocks
`timescale 1ns/1ns
`default_nettype none
module master_regs
  import master_regs_pkg::*;
#(
  parameter logic [3:0] REVISION    = 4'h5, // arbitrary value
  parameter logic [2:0] FAMILY_CODE = 3'h2  // arbitrary value
) (
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  // microprocessor register port
  input  wire logic [master_regs_pkg::ADDR_W-1:0] addr,
  input  wire logic [master_regs_pkg::DATA_W-1:0] wr_data,
  input  wire logic                          cs_n,
  input  wire logic                          wr_n,
  input  wire logic                          rd_n,
  output logic      [master_regs_pkg::DATA_W-1:0] rd_data,
  output logic                               test_sel,
  // processing block interrupts and alarms
  input  wire logic [master_regs_pkg::N_BLOCKS-1:0] block_irq,
  input  wire logic                          tx_ref_out_of_lock,
  input  wire logic                          rx_data_out_of_lock,
  input  wire logic                          rx_ref_out_of_lock,
  input  wire logic                          cell_delin_loss,
  input  wire logic                          los_alarm,
  input  wire logic                          lof_alarm,
  input  wire logic                          line_ais_alarm,
  input  wire logic                          lop_alarm,
  input  wire logic                          path_ais_alarm,
  input  wire logic                          line_bip_err,
  input  wire logic                          path_bip_err,
  // monitored clocks, asynchronous to ref_clk
  input  wire logic                          rx_ref_clk_in,
  input  wire logic                          tx_ref_clk_in,
  input  wire logic                          rx_clk_out_in,
  input  wire logic                          tx_clk_out_in,
  // datapath polarity
  input  wire logic                          rx_line_raw,
  output logic                               rx_line_data,
  input  wire logic                          rx_cell_avail_raw,
  output logic                               rx_cell_available,
  input  wire logic                          tx_cell_avail_raw,
  output logic                               tx_cell_available,
  // control outputs
  output logic                               counter_snapshot,
  output logic                               device_reset,
  output logic                               standby,
  output logic                               path_rdi_insert,
  output logic                               line_rdi_insert,
  output logic                               line_far_end_err,
  output logic                               path_far_end_err,
  output logic                               interrupt_out_n
);

  // =====================================================================
  // state
  // =====================================================================
  typedef struct packed {
    logic                sw_reset;
    logic [DATA_W-1:0]   config_bits;
    logic [DATA_W-1:0]   mctrl;
    logic [DATA_W-1:0]   synth;
    logic [DATA_W-1:0]   recov;
    logic                tx_lock_irq;
    logic                lcd_irq;
    logic                rx_lock_irq;
    logic [N_CLKMON-1:0] clk_active;
    logic                tx_lock_d;
    logic                rx_lock_d;
    logic                lcd_d;
    logic                rd_d;
    logic                wr_d;
    logic [DATA_W-1:0]   rd_data;
    logic                snapshot;
    logic                rx_line;
    logic                rx_avail;
    logic                tx_avail;
    logic                prdi;
    logic                lrdi;
    logic                lfebe;
    logic                pfebe;
  } regs_state_t;

  regs_state_t st_r;
  regs_state_t st_nxt;

  logic [N_CLKMON-1:0] clk_rise;
  logic [2:0]          lock_sync;

  if (DATA_W != 8) begin : g_width_check
    $error("master_regs: data width must be 8");
  end

  // =====================================================================
  // synchronisers for clocks and asynchronous status levels
  // =====================================================================
  edge_sync #(.WIDTH(N_CLKMON)) u_clk_sync (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .async_in  ({rx_ref_clk_in, tx_ref_clk_in,
                 rx_clk_out_in, tx_clk_out_in}),
    .level_out (),
    .rise_out  (clk_rise)
  );

  edge_sync #(.WIDTH(3)) u_lock_sync (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .async_in  ({rx_ref_out_of_lock, rx_data_out_of_lock,
                 tx_ref_out_of_lock}),
    .level_out (lock_sync),
    .rise_out  ()
  );

  // =====================================================================
  // decode
  // =====================================================================
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic normal_sel;
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_start;
  logic [7:0] int_stat;
  logic [7:0] clk_mon;

  assign normal_sel = ~addr[TEST_SEL_BIT];
  assign test_sel   = addr[TEST_SEL_BIT];
  assign rd_act     = ~cs_n & ~rd_n & normal_sel;
  assign wr_act     = ~cs_n & ~wr_n & normal_sel;
  assign rd_start   = rd_act & ~st_r.rd_d;
  assign wr_start   = wr_act & ~st_r.wr_d;

  always_comb begin
    int_stat = '0;
    int_stat[N_BLOCKS-1:0]  = block_irq;
    int_stat[TXLOCK_IRQ_BIT] = st_r.tx_lock_irq;
    int_stat[LCD_IRQ_BIT]    = st_r.lcd_irq;
    int_stat[RXLOCK_IRQ_BIT] = st_r.rx_lock_irq;
    clk_mon = '0;
    clk_mon[N_CLKMON-1:0] = st_r.clk_active;
  end

  // =====================================================================
  // next state
  // =====================================================================
  always_comb begin
    logic tx_chg;
    logic rx_chg;
    logic lcd_chg;
    tx_chg  = lock_sync[0] ^ st_r.tx_lock_d;
    rx_chg  = lock_sync[1] ^ st_r.rx_lock_d;
    lcd_chg = cell_delin_loss ^ st_r.lcd_d;
    st_nxt = st_r;
    st_nxt.rd_d      = rd_act;
    st_nxt.wr_d      = wr_act;
    st_nxt.tx_lock_d = lock_sync[0];
    st_nxt.rx_lock_d = lock_sync[1];
    st_nxt.lcd_d     = cell_delin_loss;
    st_nxt.snapshot  = 1'b0;

    // register writes; read-only and unused bits are masked off
    if (wr_start) begin
      if (hit(addr, OFF_RESET_ID)) begin
        st_nxt.sw_reset = wr_data[SW_RESET_BIT];
        st_nxt.snapshot = 1'b1;
      end
      if (hit(addr, OFF_CONFIG)) begin
        st_nxt.config_bits = wr_data & CONFIG_MASK;
      end
      if (hit(addr, OFF_MCTRL)) begin
        st_nxt.mctrl = wr_data & MCTRL_MASK;
      end
      if (hit(addr, OFF_SYNTH)) begin
        st_nxt.synth = wr_data & SYNTH_MASK;
      end
      if (hit(addr, OFF_RECOV)) begin
        st_nxt.recov = wr_data & SYNTH_MASK;
      end
    end

    // read data captured at read start
    if (rd_start) begin
      case (addr)
        OFF_RESET_ID: st_nxt.rd_data = {st_r.sw_reset, FAMILY_CODE,
                                        REVISION};
        OFF_CONFIG:   st_nxt.rd_data = st_r.config_bits;
        OFF_INT_STAT: st_nxt.rd_data = int_stat;
        OFF_CLK_MON:  st_nxt.rd_data = clk_mon;
        OFF_MCTRL: begin
          st_nxt.rd_data = st_r.mctrl;
          st_nxt.rd_data[LCD_V_BIT] = cell_delin_loss;
        end
        OFF_SYNTH: begin
          st_nxt.rd_data = st_r.synth;
          st_nxt.rd_data[TXLOCK_V_BIT] = lock_sync[0];
        end
        OFF_RECOV: begin
          st_nxt.rd_data = st_r.recov;
          st_nxt.rd_data[RXLOCK_V_BIT] = lock_sync[1];
          st_nxt.rd_data[RXREF_V_BIT]  = lock_sync[2];
        end
        default:      st_nxt.rd_data = '0;
      endcase
    end

    // clear on read, then set; a new event wins over the clear
    if (rd_start && hit(addr, OFF_INT_STAT)) begin
      st_nxt.tx_lock_irq = 1'b0;
      st_nxt.lcd_irq     = 1'b0;
      st_nxt.rx_lock_irq = 1'b0;
    end
    if (rd_start && hit(addr, OFF_CLK_MON)) begin
      st_nxt.clk_active = '0;
    end
    if (tx_chg && st_r.synth[LOCK_EN_BIT]) begin
      st_nxt.tx_lock_irq = 1'b1;
    end
    if (lcd_chg && st_r.mctrl[LCD_EN_BIT]) begin
      st_nxt.lcd_irq = 1'b1;
    end
    if (rx_chg && st_r.recov[LOCK_EN_BIT]) begin
      st_nxt.rx_lock_irq = 1'b1;
    end
    st_nxt.clk_active = st_nxt.clk_active | clk_rise;

    // datapath polarity and auto insertion
    st_nxt.rx_line  = rx_line_raw ^ st_r.config_bits[RXINV_BIT];
    st_nxt.rx_avail = rx_cell_avail_raw
                      ^ st_r.config_bits[RX_AVAIL_INV_BIT];
    st_nxt.tx_avail = tx_cell_avail_raw
                      ^ st_r.config_bits[TX_AVAIL_INV_BIT];
    st_nxt.lrdi = st_r.config_bits[ALRDI_BIT]
                  & (los_alarm | lof_alarm | line_ais_alarm);
    st_nxt.prdi = st_r.config_bits[APRDI_BIT]
                  & (los_alarm | lof_alarm | line_ais_alarm | lop_alarm
                     | path_ais_alarm | cell_delin_loss);
    st_nxt.lfebe = st_r.config_bits[AFEBE_BIT] & line_bip_err;
    st_nxt.pfebe = st_r.config_bits[AFEBE_BIT] & path_bip_err;
  end

  // =====================================================================
  // registers
  // =====================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r             <= '0;
      st_r.config_bits <= CONFIG_RESET;
      st_r.mctrl       <= MCTRL_RESET;
    end else if (st_r.sw_reset && !(wr_start && hit(addr, OFF_RESET_ID))) begin
      // software reset holds all but its own bit, rd_d, wr_d and rd_data at reset values
      st_r             <= '0;
      st_r.sw_reset    <= 1'b1;
      st_r.config_bits <= CONFIG_RESET;
      st_r.mctrl       <= MCTRL_RESET;
      st_r.rd_d        <= rd_act;
      st_r.wr_d        <= wr_act;
      st_r.rd_data     <= st_nxt.rd_data;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  assign rd_data           = st_r.rd_data;
  assign counter_snapshot  = st_r.snapshot;
  assign device_reset      = st_r.sw_reset;
  assign standby           = st_r.sw_reset;
  assign rx_line_data      = st_r.rx_line;
  assign rx_cell_available = st_r.rx_avail;
  assign tx_cell_available = st_r.tx_avail;
  assign path_rdi_insert   = st_r.prdi;
  assign line_rdi_insert   = st_r.lrdi;
  assign line_far_end_err  = st_r.lfebe;
  assign path_far_end_err  = st_r.pfebe;
  assign interrupt_out_n   = ~(|int_stat);
endmodule // master_regs
`default_nettype wire

// [testbench/master_regs_chk.sv]
// assertion checker for the master register bank
`timescale 1ns/1ns
`default_nettype none
module master_regs_chk
  import master_regs_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [7:0] rd_data,
  input wire logic       test_sel,
  input wire logic [4:0] block_irq,
  input wire logic       los_alarm,
  input wire logic       rx_line_raw,
  input wire logic       rx_line_data,
  input wire logic       rx_cell_avail_raw,
  input wire logic       rx_cell_available,
  input wire logic       counter_snapshot,
  input wire logic       device_reset,
  input wire logic       standby,
  input wire logic       line_rdi_insert,
  input wire logic       interrupt_out_n
);
  // ==========================================================
  // access start detect and configuration shadow
  logic       idle_r;
  logic [7:0] cfg_r;
  logic       rd_go;
  logic       wr_go;
  assign rd_go = !cs_n && !rd_n && idle_r && !addr[TEST_SEL_BIT];
  assign wr_go = !cs_n && !wr_n && idle_r && !addr[TEST_SEL_BIT];
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idle_r <= 1'b1;
      cfg_r  <= CONFIG_RESET;
    end else begin
      idle_r <= cs_n || (rd_n && wr_n);
      if (device_reset)
        cfg_r <= CONFIG_RESET;
      else if (wr_go && addr == OFF_CONFIG)
        cfg_r <= wr_data & CONFIG_MASK;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_test_space_flag: assert property (
    test_sel == addr[TEST_SEL_BIT])
    else $error("test select does not follow address top bit");
  a_unmapped_reads_zero: assert property (rd_go && addr == 8'h03
    |=> rd_data == 8'h00) else $error("unmapped read not zero");
  a_snapshot_on_write: assert property (counter_snapshot ==
    $past(wr_go && addr == OFF_RESET_ID)) else $error("snapshot pulse wrong");
  a_swreset_bit_set: assert property (wr_go && addr == OFF_RESET_ID
    |=> device_reset == $past(wr_data[SW_RESET_BIT]))
    else $error("software reset does not follow write");
  a_swreset_no_self: assert property (device_reset &&
    !(wr_go && addr == OFF_RESET_ID) |=> device_reset)
    else $error("software reset cleared itself");
  a_standby_tracks: assert property (standby == device_reset)
    else $error("standby differs from software reset");
  // the cycle right after a hardware reset still shows reset values
  a_rx_line_pol: assert property (
    !device_reset && !$past(device_reset) && $past(nrst)
    |-> rx_line_data == $past(rx_line_raw ^ cfg_r[RXINV_BIT]))
    else $error("receive line polarity wrong");
  a_rx_avail_pol: assert property (
    !device_reset && !$past(device_reset) && $past(nrst)
    |-> rx_cell_available
        == $past(rx_cell_avail_raw ^ cfg_r[RX_AVAIL_INV_BIT]))
    else $error("receive available polarity wrong");
  a_line_rdi_auto: assert property (
    !device_reset && !$past(device_reset) && $past(nrst)
    && $past(los_alarm && cfg_r[ALRDI_BIT]) |-> line_rdi_insert)
    else $error("line remote defect not inserted");
  a_status_read_blocks: assert property (
    rd_go && addr == OFF_INT_STAT && $stable(block_irq) && !device_reset
    |=> rd_data[4:0] == $past(block_irq)) else $error("block status wrong");
  a_irq_out_active: assert property (|block_irq && !device_reset
    |-> !interrupt_out_n) else $error("interrupt output not asserted");
  c_snapshot: cover property (counter_snapshot);
  c_status_read: cover property (rd_go && addr == OFF_INT_STAT);
  c_swreset: cover property ($rose(device_reset));
endmodule // master_regs_chk
bind master_regs master_regs_chk master_regs_chk_i (.*);
`default_nettype wire

// [testbench/test_master_regs.sv]
// self-checking bench for the master register bank
`timescale 1ns/1ns
`default_nettype none
module test_master_regs;
  import master_regs_pkg::*;
  localparam logic [3:0] REV = 4'h9; // arbitrary value
  localparam logic [2:0] FAM = 3'h5; // arbitrary value
  localparam logic [7:0] ID  = {1'b0, FAM, REV};
  logic ref_clk = 1'b0, nrst = 1'b0, cs_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data, q;
  logic [4:0] block_irq = 5'h00;
  logic tx_ref_out_of_lock = 1'b0, rx_data_out_of_lock = 1'b0;
  logic rx_ref_out_of_lock = 1'b0, cell_delin_loss = 1'b0, los_alarm = 1'b0;
  logic lof_alarm = 1'b0, line_ais_alarm = 1'b0, lop_alarm = 1'b0;
  logic path_ais_alarm = 1'b0, line_bip_err = 1'b0, path_bip_err = 1'b0;
  logic rx_ref_clk_in = 1'b0, tx_ref_clk_in = 1'b0, rx_clk_out_in = 1'b0;
  logic tx_clk_out_in = 1'b0, rx_line_raw = 1'b0, rx_cell_avail_raw = 1'b0;
  logic tx_cell_avail_raw = 1'b0, test_sel, rx_line_data, rx_cell_available;
  logic tx_cell_available, counter_snapshot, device_reset, standby, snap;
  logic path_rdi_insert, line_rdi_insert, line_far_end_err, path_far_end_err;
  logic interrupt_out_n;
  int n_errors = 0, num_checks = 0, cyc = 0;
  master_regs #(.REVISION(REV), .FAMILY_CODE(FAM)) master_regs_i (.*);
  initial forever #5 ref_clk = ~ref_clk;
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    cs_n    <= 1'b0;
    wr_n    <= !w;
    rd_n    <= w;
    @(posedge ref_clk);
    #1;
    q    = rd_data;
    snap = counter_snapshot;
    @(posedge ref_clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize;
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_values;
    rd(OFF_RESET_ID, ID);
    rd(OFF_CONFIG, CONFIG_RESET);
    rd(OFF_MCTRL, MCTRL_RESET);
    rd(OFF_INT_STAT, 8'h00);
    rd(8'h03, 8'h00);
    acc(1'b1, 8'h81, 8'hFF);
    chk({7'h0, test_sel}, 8'h01);
    rd(OFF_CONFIG, CONFIG_RESET);
  endtask
  task automatic t_config;
    logic [7:0] cf [2] = '{8'h7E, 8'h00};
    logic [7:0] n;
    acc(1'b1, OFF_CONFIG, 8'hFF);
    rd(OFF_CONFIG, CONFIG_MASK);
    @(posedge ref_clk);
    rx_line_raw       <= 1'b1;
    rx_cell_avail_raw <= 1'b1;
    los_alarm         <= 1'b1;
    lop_alarm         <= 1'b1;
    foreach (cf[i]) begin
      acc(1'b1, OFF_CONFIG, cf[i]);
      rd(OFF_CONFIG, cf[i]);
      chk({7'h0, rx_line_data}, {7'h0, !cf[i][1]});
      chk({7'h0, rx_cell_available}, {7'h0, !cf[i][2]});
      chk({7'h0, tx_cell_available}, {7'h0, cf[i][3]});
      chk({7'h0, path_rdi_insert}, {7'h0, cf[i][4]});
      chk({7'h0, line_rdi_insert}, {7'h0, cf[i][5]});
      n = 8'h00;
      @(posedge ref_clk) {line_bip_err, path_bip_err} <= 2'b11;
      @(posedge ref_clk) {line_bip_err, path_bip_err} <= 2'b00;
      repeat (4) begin
        #1;
        n = n + {7'h0, line_far_end_err} + {7'h0, path_far_end_err};
        @(posedge ref_clk);
      end
      chk(n, {6'h0, cf[i][6], 1'b0});
    end
    los_alarm <= 1'b0;
    lop_alarm <= 1'b0;
  endtask
  task automatic t_id_write;
    acc(1'b1, OFF_RESET_ID, 8'h7F);
    chk({7'h0, snap}, 8'h01);
    rd(OFF_RESET_ID, ID);
    chk({7'h0, snap}, 8'h00);
  endtask
  task automatic t_status;
    @(posedge ref_clk) block_irq <= 5'h15;
    settle();
    chk({7'h0, interrupt_out_n}, 8'h00);
    rd(OFF_INT_STAT, 8'h15);
    @(posedge ref_clk) block_irq <= 5'h0A;
    settle();
    rd(OFF_INT_STAT, 8'h0A);
    @(posedge ref_clk) block_irq <= 5'h00;
    settle();
    chk({7'h0, interrupt_out_n}, 8'h01);
    acc(1'b1, OFF_SYNTH, 8'h02);
    @(posedge ref_clk) tx_ref_out_of_lock <= 1'b1;
    settle();
    chk({7'h0, interrupt_out_n}, 8'h00);
    rd(OFF_SYNTH, 8'h0A);
    rd(OFF_INT_STAT, 8'h80);
    rd(OFF_INT_STAT, 8'h00);
    acc(1'b1, OFF_SYNTH, 8'h00);
    @(posedge ref_clk) tx_ref_out_of_lock <= 1'b0;
    settle();
    rd(OFF_INT_STAT, 8'h00);
    acc(1'b1, OFF_RECOV, 8'h02);
    @(posedge ref_clk) rx_data_out_of_lock <= 1'b1;
    settle();
    rd(OFF_INT_STAT, 8'h20);
    rd(OFF_RECOV, 8'h0A);
    @(posedge ref_clk) cell_delin_loss <= 1'b1;
    settle();
    rd(OFF_INT_STAT, 8'h00);
    acc(1'b1, OFF_MCTRL, 8'hA0);
    @(posedge ref_clk) cell_delin_loss <= 1'b0;
    settle();
    rd(OFF_INT_STAT, 8'h40);
    @(posedge ref_clk) cell_delin_loss <= 1'b1;
    settle();
    rd(OFF_INT_STAT, 8'h40);
    chk({7'h0, interrupt_out_n}, 8'h01);
    rd(OFF_MCTRL, 8'hE0);
  endtask
  task automatic t_clock_monitor;
    acc(1'b0, OFF_CLK_MON, 8'h00);
    repeat (3) begin
      repeat (3) @(posedge ref_clk);
      {rx_ref_clk_in, tx_clk_out_in} <= 2'b11;
      repeat (3) @(posedge ref_clk);
      {rx_ref_clk_in, tx_clk_out_in} <= 2'b00;
    end
    settle();
    rd(OFF_CLK_MON, 8'h09);
    rd(OFF_CLK_MON, 8'h00);
  endtask
  task automatic t_soft_reset;
    acc(1'b1, OFF_CONFIG, 8'h0E);
    rd(OFF_CONFIG, 8'h0E);
    acc(1'b1, OFF_RESET_ID, 8'h80);
    settle();
    chk({6'h0, device_reset, standby}, 8'h03);
    rd(OFF_CONFIG, CONFIG_RESET);
    acc(1'b1, OFF_RESET_ID, 8'h00);
    #1;
    chk({6'h0, device_reset, standby}, 8'h00);
    acc(1'b1, OFF_RESET_ID, 8'h80);
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    settle();
    chk({7'h0, device_reset}, 8'h00);
    rd(OFF_CONFIG, CONFIG_RESET);
  endtask
  // ==========================================================
  // main sequence and hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset_values();
    t_config();
    t_id_write();
    t_status();
    t_clock_monitor();
    t_soft_reset();
    summarize();
  end
endmodule // test_master_regs
`default_nettype wire
